// ---- design/ccp_top.v ----
// Calibration correction path: calibration registers and the correction datapath.
// Operation
// - Subtract offset B when selection picks B.
// - System offsets are 24-bit two's complement.
// - System values hold until rewritten or recalibrated.
// - System offset after self cal, before gain.
// - System offset before bipolar/unipolar scaling.
// - Multiply by gain A or B per selection.
// - Gains are unsigned 1.23 fixed point.
// - Gain range zero to just below two.
// - Self offset subtracted only when disable clear.
// - Self offset is 24-bit two's complement.
// - Self offset holds until rewritten or recalibrated.
// - Self offset subtracted before all other corrections.
// - Self offset before unipolar doubling.
// - Two-bit selection per data register: A, B, none.
// - Self gain applied before system corrections.
module ccp_top (
    // Clock and reset.
    input  wire        clock_i,
    input  wire        rst_i,
    // Register port from the serial interface logic.
    input  wire [7:0]  reg_addr_i,
    input  wire        reg_wr_i,
    input  wire [23:0] reg_wdata_i,
    output reg  [23:0] reg_rdata_o,
    // Values stored by on-demand calibration sequences.
    input  wire        cal_sys_off_we_i,
    input  wire        cal_sys_gain_we_i,
    input  wire        cal_self_off_we_i,
    input  wire        cal_set_b_i,
    input  wire [23:0] cal_value_i,
    // Mode bits.
    input  wire        self_offset_disable_i,
    input  wire        polarity_select_i,
    // Raw conversion result in.
    input  wire        raw_valid_i,
    input  wire [23:0] raw_data_i,
    input  wire [2:0]  raw_dest_i,
    input  wire [23:0] self_gain_i,
    // Corrected result out.
    output reg         res_valid_o,
    output reg  [23:0] res_data_o,
    output reg  [2:0]  res_dest_o
);
    `include "ccp_defines.vh"

    reg  [23:0] system_offset_a_q;        // System offset A.
    reg  [23:0] system_offset_b_q;        // System offset B.
    reg  [23:0] system_gain_a_q;          // System gain A.
    reg  [23:0] system_gain_b_q;          // System gain B.
    reg  [23:0] self_cal_offset_q;        // Self-calibration offset.
    reg  [15:0] cal_destination_select_q; // Per data register calibration choice.

    // Selection decode used by both the offset and the gain stage.
    function [1:0] ccp_sel;
        input [15:0] sel;
        input [2:0]  dest;
        begin
            ccp_sel = sel[{dest, 1'b0} +: 2];
        end
    endfunction

    // Register writes; calibration loads win over a software write in the same cycle.
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            system_offset_a_q        <= `CCP_RST_OFFSET;
            system_offset_b_q        <= `CCP_RST_OFFSET;
            system_gain_a_q          <= `CCP_RST_GAIN;
            system_gain_b_q          <= `CCP_RST_GAIN;
            self_cal_offset_q        <= `CCP_RST_OFFSET;
            cal_destination_select_q <= `CCP_RST_DEST_SELECT;
        end else begin
            // Software writes replace values only at their own offsets.
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `CCP_ADDR_SYSTEM_OFFSET_A: system_offset_a_q <= reg_wdata_i;
                    `CCP_ADDR_SYSTEM_OFFSET_B: system_offset_b_q <= reg_wdata_i;
                    `CCP_ADDR_SYSTEM_GAIN_A:   system_gain_a_q   <= reg_wdata_i;
                    `CCP_ADDR_SYSTEM_GAIN_B:   system_gain_b_q   <= reg_wdata_i;
                    `CCP_ADDR_SELF_CAL_OFFSET: self_cal_offset_q <= reg_wdata_i;
                    `CCP_ADDR_DEST_SELECT: begin
                        cal_destination_select_q <= reg_wdata_i[15:0];
                    end
                    default: begin
                    end
                endcase
            end
            // On-demand calibration overwrites the current value.
            if (cal_sys_off_we_i) begin
                if (cal_set_b_i) begin
                    system_offset_b_q <= cal_value_i;
                end else begin
                    system_offset_a_q <= cal_value_i;
                end
            end
            if (cal_sys_gain_we_i) begin
                if (cal_set_b_i) begin
                    system_gain_b_q <= cal_value_i;
                end else begin
                    system_gain_a_q <= cal_value_i;
                end
            end
            if (cal_self_off_we_i) begin
                self_cal_offset_q <= cal_value_i;
            end
        end
    end

    // Registered read-back; unmapped offsets read zero.
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 24'h000000;
        end else begin
            case (reg_addr_i)
                `CCP_ADDR_SYSTEM_OFFSET_A: reg_rdata_o <= system_offset_a_q;
                `CCP_ADDR_SYSTEM_OFFSET_B: reg_rdata_o <= system_offset_b_q;
                `CCP_ADDR_SYSTEM_GAIN_A:   reg_rdata_o <= system_gain_a_q;
                `CCP_ADDR_SYSTEM_GAIN_B:   reg_rdata_o <= system_gain_b_q;
                `CCP_ADDR_SELF_CAL_OFFSET: reg_rdata_o <= self_cal_offset_q;
                `CCP_ADDR_DEST_SELECT:     reg_rdata_o <= {8'h00, cal_destination_select_q};
                default:              reg_rdata_o <= 24'h000000;
            endcase
        end
    end

    // Stage 1: self offset subtraction, 26-bit signed working width.
    reg         v1_q;
    reg  [2:0]  d1_q;
    reg  [23:0] g1_q;
    reg  signed [25:0] s1_q;
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            v1_q <= 1'b0;
            d1_q <= 3'h0;
            g1_q <= 24'h000000;
            s1_q <= 26'h0000000;
        end else begin
            v1_q <= raw_valid_i;
            d1_q <= raw_dest_i;
            g1_q <= self_gain_i;
            // Both operands are sign extended two's complement.
            if (self_offset_disable_i) begin
                s1_q <= {{2{raw_data_i[23]}}, raw_data_i};
            end else begin
                s1_q <= {{2{raw_data_i[23]}}, raw_data_i}
                        - {{2{self_cal_offset_q[23]}}, self_cal_offset_q};
            end
        end
    end

    // Stage 2: self gain multiply.
    wire signed [25:0] p2_w;
    ccp_gain_mul #(.W(24)) u_self_mul (
        .value_i   (s1_q),
        .gain_i    (g1_q),
        .product_o (p2_w)
    );
    reg         v2_q;
    reg  [2:0]  d2_q;
    reg  signed [25:0] s2_q;
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            v2_q <= 1'b0;
            d2_q <= 3'h0;
            s2_q <= 26'h0000000;
        end else begin
            v2_q <= v1_q;
            d2_q <= d1_q;
            s2_q <= p2_w;
        end
    end

    // Stage 3: system offset per selection.
    wire [1:0]  sel2_w  = ccp_sel(cal_destination_select_q, d2_q);
    wire [23:0] soff_w  = (sel2_w == `CCP_SEL_SET_B) ? system_offset_b_q : system_offset_a_q;
    // One extra bit so the difference cannot wrap before it is clamped.
    wire signed [26:0] dif3_w = {s2_q[25], s2_q} - {{3{soff_w[23]}}, soff_w};
    reg         v3_q;
    reg  [2:0]  d3_q;
    reg  signed [25:0] s3_q;
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            v3_q <= 1'b0;
            d3_q <= 3'h0;
            s3_q <= 26'h0000000;
        end else begin
            v3_q <= v2_q;
            d3_q <= d2_q;
            // Codes 10 and 11 skip system calibration.
            if (sel2_w[1]) begin
                s3_q <= s2_q;
            end else if (dif3_w > $signed(27'h1FFFFFF)) begin
                // Clamp to the largest positive working value.
                s3_q <= 26'h1FFFFFF;
            end else if (dif3_w < -$signed(27'h1FFFFFF)) begin
                // Clamp to the mirror of the positive bound.
                s3_q <= 26'h2000001;
            end else begin
                s3_q <= dif3_w[25:0];
            end
        end
    end

    // Stage 4: system gain per selection.
    wire [1:0]  sel3_w  = ccp_sel(cal_destination_select_q, d3_q);
    wire [23:0] sgain_w = (sel3_w == `CCP_SEL_SET_B) ? system_gain_b_q
                                                     : system_gain_a_q;
    wire signed [25:0] p4_w;
    ccp_gain_mul #(.W(24)) u_sys_mul (
        .value_i   (s3_q),
        .gain_i    (sgain_w),
        .product_o (p4_w)
    );
    reg         v4_q;
    reg  [2:0]  d4_q;
    reg  signed [25:0] s4_q;
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            v4_q <= 1'b0;
            d4_q <= 3'h0;
            s4_q <= 26'h0000000;
        end else begin
            v4_q <= v3_q;
            d4_q <= d3_q;
            s4_q <= sel3_w[1] ? s3_q : p4_w;
        end
    end

    // Stage 5: bipolar x1 or unipolar x2 scaling after all corrections, clamped to 24 bits.
    wire signed [26:0] sc_w = polarity_select_i ? {s4_q, 1'b0} : {s4_q[25], s4_q};
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            res_valid_o <= 1'b0;
            res_dest_o  <= 3'h0;
            res_data_o  <= 24'h000000;
        end else begin
            res_valid_o <= v4_q;
            res_dest_o  <= d4_q;
            if (sc_w > $signed(27'h07FFFFF)) begin
                res_data_o <= 24'h7FFFFF;
            end else if (sc_w < $signed(27'h7800000)) begin
                res_data_o <= 24'h800000;
            end else begin
                res_data_o <= sc_w[23:0];
            end
        end
    end
endmodule

// ---- design/ccp_defines.vh ----
// Register offsets, field positions, codes and reset values for the calibration correction path.
`ifndef CCP_DEFINES_VH
`define CCP_DEFINES_VH
`define CCP_ADDR_SYSTEM_OFFSET_A 8'h13
`define CCP_ADDR_SYSTEM_OFFSET_B 8'h14
`define CCP_ADDR_SYSTEM_GAIN_A   8'h15
`define CCP_ADDR_SYSTEM_GAIN_B   8'h16
`define CCP_ADDR_SELF_CAL_OFFSET 8'h17
`define CCP_ADDR_SELF_GAIN       8'h18
`define CCP_ADDR_DEST_SELECT     8'h12
`define CCP_SEL_SET_A         2'h0
`define CCP_SEL_SET_B         2'h1
`define CCP_RST_OFFSET        24'h000000
`define CCP_RST_GAIN          24'h800000
`define CCP_RST_DEST_SELECT   16'h0000
`define CCP_GAIN_FRAC_BITS    23
`define CCP_PIPE_STAGES       5
`endif

// ---- design/ccp_gain_mul.v ----
// Signed result times unsigned 1.23 fixed-point gain, with saturation to the W+2-bit working width.
module ccp_gain_mul #(
    parameter W = 24
) (
    // Operands.
    input  wire signed [W+1:0] value_i,
    input  wire        [W-1:0] gain_i,
    // Product.
    output reg  signed [W+1:0] product_o
);
    `include "ccp_defines.vh"

    // Full precision product; the gain is extended with a zero sign bit.
    wire signed [2*W+2:0] full_w = value_i * $signed({1'b0, gain_i});
    // Product scaled back by the fractional weight of the gain.
    wire signed [2*W+2:0] shr_w  = full_w >>> `CCP_GAIN_FRAC_BITS;

    // Clamp the scaled product into the working width.
    always @* begin
        if (shr_w > $signed({{(W+2){1'b0}}, {(W+1){1'b1}}})) begin
            // Largest positive working value, the same bound as the test above.
            product_o = {1'b0, {(W+1){1'b1}}};
        end else if (shr_w < -$signed({{(W+2){1'b0}}, {(W+1){1'b1}}})) begin
            // Mirror of the positive bound, so the clamp is symmetric.
            product_o = {1'b1, {W{1'b0}}, 1'b1};
        end else begin
            product_o = shr_w[W+1:0];
        end
    end
endmodule

// ---- sim/ccp_chk.sv ----
// Port checker for the calibration correction path.
module ccp_chk (
    // Clock and reset.
    input wire logic        clock_i,
    input wire logic        rst_i,
    // Register port and calibration stores.
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic [23:0] reg_wdata_i,
    input wire logic [23:0] reg_rdata_o,
    input wire logic        cal_sys_off_we_i,
    input wire logic        cal_self_off_we_i,
    input wire logic        cal_set_b_i,
    input wire logic [23:0] cal_value_i,
    // Sample path.
    input wire logic        raw_valid_i,
    input wire logic [2:0]  raw_dest_i,
    input wire logic        res_valid_o,
    input wire logic [2:0]  res_dest_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    a_wr_rd_b: assert property ((reg_wr_i && reg_addr_i == 8'h14 && !cal_sys_off_we_i) ##1
        (reg_addr_i == 8'h14) |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("offset B readback");
    a_hold_b: assert property ((reg_addr_i == 8'h14 && !reg_wr_i && !cal_sys_off_we_i) ##1
        (reg_addr_i == 8'h14) |=> $stable(reg_rdata_o)) else $error("offset B drifted");
    a_cal_off_b: assert property ((cal_sys_off_we_i && cal_set_b_i) ##1 (reg_addr_i == 8'h14)
        |=> reg_rdata_o == $past(cal_value_i, 2)) else $error("offset B calibration store");
    a_cal_self: assert property ((cal_self_off_we_i) ##1 (reg_addr_i == 8'h17)
        |=> reg_rdata_o == $past(cal_value_i, 2)) else $error("self offset calibration store");
    a_unmapped_zero: assert property (reg_addr_i > 8'h18 |=> reg_rdata_o == 24'h000000)
        else $error("unmapped read not zero");
    a_result_lat: assert property (raw_valid_i |-> ##5 res_valid_o)
        else $error("result missing after five cycles");
    a_no_spurious: assert property (res_valid_o |-> $past(raw_valid_i, 5))
        else $error("result without a sample");
    a_dest_kept: assert property (raw_valid_i |-> ##5 res_dest_o == $past(raw_dest_i, 5))
        else $error("destination index changed");
endmodule

bind ccp_top ccp_chk u_chk (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .cal_sys_off_we_i(cal_sys_off_we_i), .cal_self_off_we_i(cal_self_off_we_i),
    .cal_set_b_i(cal_set_b_i), .cal_value_i(cal_value_i), .raw_valid_i(raw_valid_i),
    .raw_dest_i(raw_dest_i), .res_valid_o(res_valid_o), .res_dest_o(res_dest_o));

// ---- sim/ccp_tb.sv ----
// Self-checking testbench for the calibration correction path.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i = 0, rst_i = 1, reg_wr_i = 0, raw_valid_i = 0, cal_set_b_i = 0;
    logic        cal_sys_off_we_i = 0, cal_sys_gain_we_i = 0, cal_self_off_we_i = 0;
    logic        self_offset_disable_i = 0, polarity_select_i = 0, res_valid_o;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [23:0] reg_wdata_i = 0, cal_value_i = 0, raw_data_i = 0, self_gain_i = 24'h800000;
    logic [23:0] reg_rdata_o, res_data_o;
    logic [2:0]  raw_dest_i = 0, res_dest_o;
    logic [23:0] sh [6] = '{0, 0, 0, 24'h800000, 24'h800000, 0}; // Shadow of 0x12..0x17.
    logic [26:0] exp_q [$];                                       // Expected {dest, data}.
    logic [26:0] me;
    logic [31:0] v;
    int          bad_count = 0, compares = 0, i, m;

    ccp_top dut (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .cal_sys_off_we_i(cal_sys_off_we_i),
        .cal_sys_gain_we_i(cal_sys_gain_we_i), .cal_self_off_we_i(cal_self_off_we_i),
        .cal_set_b_i(cal_set_b_i), .cal_value_i(cal_value_i), .raw_valid_i(raw_valid_i),
        .self_offset_disable_i(self_offset_disable_i), .polarity_select_i(polarity_select_i),
        .raw_data_i(raw_data_i), .raw_dest_i(raw_dest_i), .self_gain_i(self_gain_i),
        .res_valid_o(res_valid_o), .res_data_o(res_data_o), .res_dest_o(res_dest_o));

    // The clock toggles every 2 ns, half of its 4 ns period.
    always #2 clock_i = ~clock_i;

    // Counts a comparison and reports a mismatch at once.
    task automatic chk(string n, logic [26:0] e, logic [26:0] s);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic finish_test;
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Raises a write; the next read lowers every strobe, so none is set twice in a step.
    task automatic wr(logic [7:0] a, logic [23:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
    endtask

    // Raises one calibration store: 0 system offset, 1 system gain, 2 self offset.
    task automatic cw(int k, logic b, logic [23:0] d);
        {cal_self_off_we_i, cal_sys_gain_we_i, cal_sys_off_we_i} <= 3'b001 << k;
        cal_set_b_i <= b;
        cal_value_i <= d;
        @(posedge clock_i);
    endtask

    // Holds the address two edges; read data is settled and stands while it is held.
    task automatic rd(logic [7:0] a, logic [23:0] e);
        {reg_wr_i, cal_self_off_we_i, cal_sys_gain_we_i, cal_sys_off_we_i} <= 4'h0;
        reg_addr_i <= a;
        repeat (2) @(posedge clock_i);
        chk("rdata", {3'h0, e}, {3'h0, reg_rdata_o});
    endtask

    // Reference arithmetic: self offset, self gain, then the selected system set and scaling.
    function automatic logic [26:0] model(logic [23:0] r, logic [2:0] d);
        longint s;
        logic [1:0] c;
        c = sh[0][2*d +: 2];
        s = longint'($signed(r));
        if (!self_offset_disable_i) s -= longint'($signed(sh[5]));
        s = (s * longint'(self_gain_i)) >>> 23;
        if (!c[1]) s = ((s - longint'($signed(c[0] ? sh[2] : sh[1])))
            * longint'(c[0] ? sh[4] : sh[3])) >>> 23;
        if (polarity_select_i) s = s * 2;
        s = s > 8388607 ? 8388607 : (s < -8388608 ? -8388608 : s);
        return {d, s[23:0]};
    endfunction

    // Takes the oldest note whenever a result appears and compares it.
    always @(posedge clock_i) begin
        if (res_valid_o === 1'b1) begin
            me = exp_q.size() ? exp_q.pop_front() : 27'bx;
            chk("result", me, {res_dest_o, res_data_o});
        end
    end

    // Main sequence: defaults, writes, calibration stores, then sample bursts per mode.
    initial begin
        void'($urandom(32'hEA88));
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        for (i = 0; i < 6; i++) rd(8'h12 + 8'(i), sh[i]);
        rd(8'h30, 24'h000000);
        for (i = 0; i < 6; i++) begin
            v = $urandom;
            sh[i] = (i == 0) ? 24'h00E4E4 : (i == 3 || i == 4) ? v[23:0] : {{4{v[19]}}, v[19:0]};
            wr(8'h12 + 8'(i), sh[i]);
            rd(8'h12 + 8'(i), sh[i]);
        end
        v = $urandom;
        sh[2] = {{4{v[19]}}, v[19:0]};
        cw(0, 1'b1, sh[2]);
        rd(8'h14, sh[2]);
        sh[5] = {{4{v[23]}}, v[23:4]};
        cw(2, 1'b0, sh[5]);
        rd(8'h17, sh[5]);
        sh[3] = 24'hFFFFFF;
        cw(1, 1'b0, sh[3]);
        rd(8'h15, sh[3]);
        for (m = 0; m < 4; m++) begin
            {self_offset_disable_i, polarity_select_i} <= m[1:0];
            self_gain_i <= 24'h600000 + 24'($urandom_range(0, 4194303));
            @(posedge clock_i);
            for (i = 0; i < 16; i++) begin
                v = $urandom;
                raw_valid_i <= 1'b1;
                raw_data_i <= v[23:0];
                raw_dest_i <= v[26:24];
                exp_q.push_back(model(v[23:0], v[26:24]));
                @(posedge clock_i);
            end
            raw_valid_i <= 1'b0;
            repeat (8) @(posedge clock_i);
        end
        chk("pending", 27'h0, 27'(exp_q.size()));
        finish_test();
    end
endmodule
